// *** inc/ccte_pkg.sv ***
package ccte_pkg;

  localparam int CLK_HZ = 250_000_000;
  localparam int FREQ_SLOW_HZ = 60_000;
  localparam int FREQ_FAST_HZ = 100_000;
  // Least half period of the pulse input, rounded up to whole cycles.
  localparam logic [11:0] FILT_SLOW_CYC =
    12'((CLK_HZ + 2 * FREQ_SLOW_HZ - 1) / (2 * FREQ_SLOW_HZ));
  localparam logic [11:0] FILT_FAST_CYC =
    12'((CLK_HZ + 2 * FREQ_FAST_HZ - 1) / (2 * FREQ_FAST_HZ));

  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_LOAD = 12'h004;
  localparam logic [11:0] REG_MODE = 12'h008;
  localparam logic [11:0] REG_NEWVAL = 12'h00C;
  localparam logic [11:0] REG_COUNT = 12'h010;
  localparam logic [11:0] REG_STATUS = 12'h014;
  localparam logic [11:0] REG_INT_STAT = 12'h018;
  localparam logic [11:0] REG_INT_MASK = 12'h01C;
  localparam logic [11:0] REG_TABLE_BASE = 12'h100;
  localparam int TABLE_WORDS = 40;

  localparam int CTRL_RING_BIT = 0;
  localparam int CTRL_CONT_BIT = 1;
  localparam int CTRL_FAST_BIT = 2;
  localparam int CTRL_SWRST_BIT = 3;
  localparam int STAT_CMP_BIT = 8;
  localparam int STAT_RNG_BIT = 9;
  localparam int STAT_SUSP_BIT = 10;
  localparam int STAT_ENTRY_LSB = 16;

  localparam int MAX_ENTRIES = 8;
  localparam int TGT_COUNT_IDX = 0;
  localparam int TGT_BASE = 1;
  localparam int TGT_STRIDE = 3;
  localparam int RNG_STRIDE = 5;
  localparam int CTL_DIR_BIT = 15;
  localparam logic [15:0] CTL_DISABLED = 16'hFFFF;
  localparam logic [15:0] CTL_NO_TASK = 16'hAAAA;

  localparam logic [31:0] RING_MAX_RST = 32'hFFFF_FFFF;
  localparam logic [7:0] MASK_RST = 8'h00;

  typedef enum logic [2:0] {
    LOAD_TGT_START = 3'h0,
    LOAD_RNG_START = 3'h1,
    LOAD_TGT = 3'h2,
    LOAD_RNG = 3'h3
  } ccte_load_t;

  typedef enum logic [2:0] {
    MODE_START = 3'h0,
    MODE_STOP = 3'h1,
    MODE_SET_COUNT = 3'h2,
    MODE_SET_MAX = 3'h6
  } ccte_mode_t;

  typedef enum logic {
    DISP_IDLE = 1'b0,
    DISP_SERVE = 1'b1
  } ccte_disp_t;

  typedef struct packed {
    logic [31:0] count;
    logic stepped;
    logic down;
    logic was_reset;
  } ccte_cnt_t;

  typedef logic [TABLE_WORDS-1:0][15:0] ccte_table_t;

endpackage

// *** core/ccte_counter.sv ***
`timescale 1ns/1ps
module ccte_counter
  import ccte_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic up_pin,
  input wire logic down_pin,
  input wire logic fast_sel,
  input wire logic ring_mode,
  input wire logic [31:0] ring_max,
  input wire logic load_en,
  input wire logic [31:0] load_val,
  input wire logic sw_reset,
  output ccte_cnt_t cnt
);

  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] lvl;
    logic [1:0][11:0] fcnt;
    ccte_cnt_t c;
  } ccte_ctr_st_t;

  ccte_ctr_st_t st;
  ccte_ctr_st_t next_st;

  always_comb
  begin
    logic [1:0] rise;
    logic [11:0] lim;
    next_st = st;
    rise = 2'h0;
    lim = fast_sel ? FILT_FAST_CYC : FILT_SLOW_CYC;
    next_st.c.stepped = 1'b0;
    next_st.c.was_reset = 1'b0;
    next_st.s1 = {down_pin, up_pin};
    next_st.s2 = st.s1;
    // A level must hold for half the period of the rate picked by fast_sel (60 kHz or 100 kHz); faster noise is dropped.
    for (int i = 0; i < 2; i++)
    begin
      if (st.s2[i] == st.lvl[i])
        next_st.fcnt[i] = 12'h000;
      else if (st.fcnt[i] >= lim - 12'h001)
      begin
        next_st.fcnt[i] = 12'h000;
        next_st.lvl[i] = st.s2[i];
        rise[i] = st.s2[i];
      end
      else
        next_st.fcnt[i] = st.fcnt[i] + 12'h001;
    end
    if (sw_reset)
    begin
      next_st.c.count = 32'h0000_0000;
      next_st.c.was_reset = 1'b1;
    end
    else if (load_en)
      next_st.c.count = load_val;
    else if (rise == 2'b01)
    begin
      next_st.c.stepped = 1'b1;
      next_st.c.down = 1'b0;
      if (ring_mode && st.c.count >= ring_max)
        next_st.c.count = 32'h0000_0000;
      else if (ring_mode || st.c.count != 32'hFFFF_FFFF)
        next_st.c.count = st.c.count + 32'h0000_0001;
      else
        next_st.c.stepped = 1'b0;
    end
    else if (rise == 2'b10)
    begin
      next_st.c.stepped = 1'b1;
      next_st.c.down = 1'b1;
      if (st.c.count == 32'h0000_0000)
      begin
        next_st.c.count = ring_max;
        next_st.c.stepped = ring_mode;
        if (!ring_mode)
          next_st.c.count = 32'h0000_0000;
      end
      else
        next_st.c.count = st.c.count - 32'h0000_0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= '0;
    else if (ce)
      st <= next_st;
  end

  assign cnt = st.c;

endmodule

// *** core/ccte_cmp.sv ***
`timescale 1ns/1ps
module ccte_cmp
  import ccte_pkg::*;
(
  input ccte_table_t tbl,
  input wire logic range_mode,
  input ccte_cnt_t cnt,
  input wire logic [7:0] prev_in,
  output logic [7:0] hit,
  output logic [7:0] in_range,
  output logic [7:0][7:0] task_nums
);

  function automatic logic [31:0] word32(input logic [15:0] lo, input logic [15:0] hi);
    word32 = {hi, lo};
  endfunction

  genvar i;
  generate
    for (i = 0; i < MAX_ENTRIES; i++)
    begin : g_entry
      localparam int T = TGT_BASE + TGT_STRIDE * i;
      localparam int R = RNG_STRIDE * i;
      logic [15:0] tctl;
      logic [15:0] rctl;
      logic tgt_used;
      logic tgt_hit;
      logic [31:0] lo;
      logic [31:0] hi;
      assign tctl = tbl[T + 2];
      assign rctl = tbl[R + 4];
      assign tgt_used = tbl[TGT_COUNT_IDX] > 16'(i);
      // Target hits only on the step that lands on it, in the tagged direction.
      assign tgt_hit = tgt_used && cnt.stepped && (cnt.count == word32(tbl[T], tbl[T + 1]))
        && (cnt.down == tctl[CTL_DIR_BIT]);
      assign lo = word32(tbl[R], tbl[R + 1]);
      assign hi = word32(tbl[R + 2], tbl[R + 3]);
      assign in_range[i] = range_mode && (rctl != CTL_DISABLED)
        && (cnt.count >= lo) && (cnt.count <= hi);
      // Entering or leaving is picked by the direction bit.
      assign hit[i] = range_mode
        ? ((rctl != CTL_NO_TASK) && (rctl[CTL_DIR_BIT]
          ? (prev_in[i] && !in_range[i]) : (in_range[i] && !prev_in[i])))
        : tgt_hit;
      assign task_nums[i] = range_mode ? rctl[7:0] : tctl[7:0];
    end
  endgenerate

endmodule

// *** core/ccte_top.sv ***
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module ccte_top
  import ccte_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic up_pulse,
  input wire logic down_pulse,
  output logic irq,
  output logic cyclic_suspend,
  output logic [7:0] task_num
);

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic ring_mode;
    logic cont_after_reset;
    logic fast_sel;
    logic sw_reset;
    logic count_load;
    logic [31:0] newval;
    logic [31:0] ring_max;
    ccte_table_t tbl;
    logic range_mode;
    logic comparing;
    logic [7:0] prev_in;
    logic [7:0] pend;
    logic [7:0] mask;
    logic irq;
    ccte_disp_t disp;
    logic [2:0] cur_entry;
    logic [7:0] task_num;
  } ccte_top_st_t;

  ccte_top_st_t st;
  ccte_top_st_t next_st;
  ccte_cnt_t cnt;
  logic [7:0] hit;
  logic [7:0] in_range;
  logic [7:0][7:0] task_nums;

  function automatic logic is_table(input logic [11:0] a);
    is_table = (a >= REG_TABLE_BASE) && (a < REG_TABLE_BASE + 12'(4 * TABLE_WORDS));
  endfunction

  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = is_table(a) || (a[1:0] == 2'b00 && a <= REG_INT_MASK);
  endfunction

  function automatic logic [2:0] first_set(input logic [7:0] v);
    first_set = 3'h0;
    for (int k = MAX_ENTRIES - 1; k >= 0; k--)
    begin
      if (v[k])
        first_set = 3'(k);
    end
  endfunction

  ccte_counter u_counter (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .up_pin(up_pulse),
    .down_pin(down_pulse),
    .fast_sel(st.fast_sel),
    .ring_mode(st.ring_mode),
    .ring_max(st.ring_max),
    .load_en(st.count_load),
    .load_val(st.newval),
    .sw_reset(st.sw_reset),
    .cnt(cnt)
  );

  ccte_cmp u_cmp (
    .tbl(st.tbl),
    .range_mode(st.range_mode),
    .cnt(cnt),
    .prev_in(st.prev_in),
    .hit(hit),
    .in_range(in_range),
    .task_nums(task_nums)
  );

  always_comb
  begin
    logic setup;
    logic wr;
    logic [7:0] ack;
    logic [7:0] live;
    logic [5:0] idx;
    logic active;
    next_st = st;
    setup = psel && !penable;
    wr = psel && penable && st.pready && pwrite && is_mapped(paddr);
    ack = 8'h00;
    idx = 6'((paddr - REG_TABLE_BASE) >> 2);
    next_st.sw_reset = 1'b0;
    next_st.count_load = 1'b0;

    // Zero-wait slave: ready rises in the access cycle straight after setup.
    next_st.pready = setup;
    next_st.pslverr = setup && !is_mapped(paddr);
    next_st.prdata = 32'h0000_0000;
    if (setup && !pwrite)
    begin
      if (is_table(paddr))
        next_st.prdata = {16'h0000, st.tbl[idx]};
      else
      begin
        case (paddr)
          REG_CTRL:
            next_st.prdata = {28'h0000000, 1'b0, st.fast_sel, st.cont_after_reset, st.ring_mode};
          REG_NEWVAL:
            next_st.prdata = st.newval;
          REG_COUNT:
            next_st.prdata = cnt.count;
          REG_STATUS:
          begin
            next_st.prdata[7:0] = st.prev_in;
            next_st.prdata[STAT_CMP_BIT] = st.comparing;
            next_st.prdata[STAT_RNG_BIT] = st.range_mode;
            next_st.prdata[STAT_SUSP_BIT] = st.disp == DISP_SERVE;
            next_st.prdata[STAT_ENTRY_LSB +: 3] = st.cur_entry;
          end
          REG_INT_STAT:
            next_st.prdata = {24'h000000, st.pend};
          REG_INT_MASK:
            next_st.prdata = {24'h000000, st.mask};
          default:
            next_st.prdata = 32'h0000_0000;
        endcase
      end
    end

    if (wr)
    begin
      if (is_table(paddr))
        next_st.tbl[idx] = pwdata[15:0];
      else
      begin
        case (paddr)
          REG_CTRL:
          begin
            next_st.ring_mode = pwdata[CTRL_RING_BIT];
            next_st.cont_after_reset = pwdata[CTRL_CONT_BIT];
            next_st.fast_sel = pwdata[CTRL_FAST_BIT];
            next_st.sw_reset = pwdata[CTRL_SWRST_BIT];
          end
          REG_LOAD:
          begin
            next_st.prev_in = 8'h00;
            case (ccte_load_t'(pwdata[2:0]))
              LOAD_TGT_START:
              begin
                next_st.range_mode = 1'b0;
                next_st.comparing = 1'b1;
              end
              LOAD_RNG_START:
              begin
                next_st.range_mode = 1'b1;
                next_st.comparing = 1'b1;
              end
              LOAD_TGT:
                next_st.range_mode = 1'b0;
              LOAD_RNG:
                next_st.range_mode = 1'b1;
              default:
                next_st.range_mode = st.range_mode;
            endcase
          end
          REG_MODE:
          begin
            case (ccte_mode_t'(pwdata[2:0]))
              MODE_START:
                next_st.comparing = 1'b1;
              MODE_STOP:
                next_st.comparing = 1'b0;
              MODE_SET_COUNT:
                next_st.count_load = 1'b1;
              MODE_SET_MAX:
                next_st.ring_max = st.newval;
              default:
                next_st.comparing = st.comparing;
            endcase
          end
          REG_NEWVAL:
            next_st.newval = pwdata;
          REG_INT_STAT:
            ack = pwdata[7:0];
          REG_INT_MASK:
            next_st.mask = pwdata[7:0];
          default:
            next_st.mask = st.mask;
        endcase
      end
    end

    // A reset drop out of a range must not count as leaving it, so the
    // reset cycle itself never raises a task.
    active = st.comparing && !cnt.was_reset;
    if (cnt.was_reset && !st.cont_after_reset)
      next_st.comparing = 1'b0;
    next_st.prev_in = (st.comparing && !(wr && paddr == REG_LOAD)) ? in_range : 8'h00;

    // Set wins over the acknowledge in the same cycle.
    next_st.pend = (st.pend & ~ack) | (hit & {8{active}});
    live = next_st.pend & next_st.mask;
    next_st.irq = |live;

    case (st.disp)
      DISP_IDLE:
      begin
        if (|(st.pend & st.mask))
        begin
          // Only the lowest-numbered pending entry is served; others wait their turn.
          next_st.cur_entry = first_set(st.pend & st.mask);
          next_st.task_num = task_nums[first_set(st.pend & st.mask)];
          next_st.disp = DISP_SERVE;
        end
      end
      DISP_SERVE:
      begin
        if (!next_st.pend[st.cur_entry])
          next_st.disp = DISP_IDLE;
      end
      default:
        next_st.disp = DISP_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= '0;
      st.ring_max <= RING_MAX_RST;
      st.mask <= MASK_RST;
    end
    else if (ce)
      st <= next_st;
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign irq = st.irq;
  assign cyclic_suspend = st.disp == DISP_SERVE;
  assign task_num = st.task_num;

endmodule

// *** dv/ccte_props.sv ***
`timescale 1ns/1ps
module ccte_props
  import ccte_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic up_pulse,
  input wire logic down_pulse,
  input wire logic irq,
  input wire logic cyclic_suspend,
  input wire logic [7:0] task_num
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  ready_single_a: assert property (pready |=> !pready)
    else $error("pready stood longer than one cycle");
  ready_setup_a: assert property (ce && psel && !penable |=> pready)
    else $error("no answer in the access cycle");
  ready_cause_a: assert property (pready |-> $past(psel && !penable))
    else $error("pready without a setup cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr outside an answer");
  task_hold_a: assert property (cyclic_suspend && $past(cyclic_suspend) |-> $stable(task_num))
    else $error("task number changed while served");
  suspend_cause_a: assert property ($rose(cyclic_suspend) |-> $past(irq))
    else $error("service began without a request");
  resume_ack_a: assert property ($fell(cyclic_suspend) |->
    $past(psel && penable && pwrite && paddr == REG_INT_STAT))
    else $error("service ended without acknowledge");
  irq_fall_a: assert property ($fell(irq) |-> $past(psel && penable && pwrite))
    else $error("request dropped without a write");
  irq_serve_a: assert property (irq |-> ##[0:2] cyclic_suspend)
    else $error("pending request not served");

  cover property ($rose(cyclic_suspend));
  cover property ($fell(cyclic_suspend));
  cover property (pslverr);
endmodule

bind ccte_top ccte_props ccte_props_inst (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .up_pulse(up_pulse), .down_pulse(down_pulse), .irq(irq),
  .cyclic_suspend(cyclic_suspend), .task_num(task_num)
);

// *** dv/ccte_host_model.sv ***
`timescale 1ns/1ps
module ccte_host_model
  import ccte_pkg::*;
(
  input wire logic pclk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end

  // Read data and the error flag are taken at the rising edge that shows pready high.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      tb_top.mismatches++;
      tb_top.finish_test();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    xfer(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] q, output logic e);
    xfer(1'b0, a, 32'h0000_0000, q, e);
  endtask

  // All forty words are always written; ranges after the first are disabled.
  task automatic load_rng(input logic [31:0] lo, input logic [31:0] hi, input logic [15:0] ctl);
    logic [31:0] l;
    logic [31:0] h;
    logic [15:0] c;
    logic [15:0] w;
    for (int i = 0; i < TABLE_WORDS; i++)
    begin
      l = (i < 5) ? lo : 32'h0000_0000;
      h = (i < 5) ? hi : 32'hFFFF_FFFF;
      c = (i < 5) ? ctl : CTL_DISABLED;
      case (i % 5)
        0: w = l[15:0];
        1: w = l[31:16];
        2: w = h[15:0];
        3: w = h[31:16];
        default: w = c;
      endcase
      wr(REG_TABLE_BASE + 12'(4 * i), {16'h0000, w});
    end
  endtask
endmodule

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  import ccte_pkg::*;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic up_pulse, down_pulse, irq, cyclic_suspend, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [7:0] task_num;
  int mismatches, comparisons;

  ccte_top ccte_top_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .up_pulse(up_pulse), .down_pulse(down_pulse),
    .irq(irq), .cyclic_suspend(cyclic_suspend), .task_num(task_num));
  ccte_host_model ccte_host_model_inst (.pclk(pclk), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata));

  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      mismatches++;
    end
  endtask

  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic set_count(input logic [31:0] v);
    ccte_host_model_inst.wr(REG_NEWVAL, v);
    ccte_host_model_inst.wr(REG_MODE, 32'h0000_0002);
  endtask

  // Waits for service, checks the task, then acknowledges only the given entries.
  task automatic serve(input logic [7:0] exp_t, input logic [7:0] ack);
    int n;
    n = 0;
    @(negedge pclk);
    while (cyclic_suspend !== 1'b1 && n < 1600)
    begin
      @(negedge pclk);
      n++;
    end
    check("serving", 32'h1, {31'h0, cyclic_suspend});
    check("task", {24'h0, exp_t}, {24'h0, task_num});
    check("irq set", 32'h1, {31'h0, irq});
    ccte_host_model_inst.wr(REG_INT_STAT, {24'h0, ack});
  endtask

  // One filtered pulse; the hold time exceeds the 100 kHz filter count.
  task automatic step(input logic dn, input logic exp_s, input logic [7:0] exp_t);
    if (dn)
      down_pulse <= 1'b1;
    else
      up_pulse <= 1'b1;
    if (exp_s)
      serve(exp_t, 8'hFF);
    else
    begin
      repeat (1600) @(negedge pclk);
      check("serving", 32'h0, {31'h0, cyclic_suspend});
    end
    @(posedge pclk);
    up_pulse <= 1'b0;
    down_pulse <= 1'b0;
    repeat (1300) @(posedge pclk);
    @(negedge pclk);
    check("resumed", 32'h0, {31'h0, cyclic_suspend});
    check("irq", 32'h0, {31'h0, irq});
  endtask

  initial
  begin
    mismatches = 0;
    comparisons = 0;
    presetn = 1'b0;
    ce = 1'b1;
    up_pulse = 1'b0;
    down_pulse = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    ccte_host_model_inst.rd(REG_INT_MASK, q, err);
    check("mask reset", 32'h0, q);
    ccte_host_model_inst.rd(12'h020, q, err);
    check("unmapped err", 32'h1, {31'h0, err});
    ccte_host_model_inst.wr(REG_CTRL, 32'h0000_0004);
    ccte_host_model_inst.wr(REG_INT_MASK, 32'h0000_00FF);
    ccte_host_model_inst.wr(REG_TABLE_BASE, 32'h0000_0002);
    ccte_host_model_inst.wr(REG_TABLE_BASE + 12'h004, 32'h0000_7530);
    ccte_host_model_inst.wr(REG_TABLE_BASE + 12'h008, 32'h0000_0000);
    ccte_host_model_inst.wr(REG_TABLE_BASE + 12'h00C, 32'h0000_000A);
    ccte_host_model_inst.wr(REG_TABLE_BASE + 12'h010, 32'h0000_4E20);
    ccte_host_model_inst.wr(REG_TABLE_BASE + 12'h014, 32'h0000_0000);
    ccte_host_model_inst.wr(REG_TABLE_BASE + 12'h018, 32'h0000_800B);
    set_count(32'h0000_752F);
    ccte_host_model_inst.wr(REG_LOAD, 32'h0000_0000);
    ccte_host_model_inst.rd(REG_STATUS, q, err);
    check("comparing", 32'h1, {31'h0, q[STAT_CMP_BIT]});
    step(1'b0, 1'b1, 8'h0A);
    ccte_host_model_inst.rd(REG_COUNT, q, err);
    check("count", 32'h0000_7530, q);
    set_count(32'h0000_4E1F);
    step(1'b0, 1'b0, 8'h00);
    set_count(32'h0000_4E21);
    step(1'b1, 1'b1, 8'h0B);
    ccte_host_model_inst.load_rng(32'h0000_61A8, 32'h0000_639C, 16'h000C);
    set_count(32'h0000_61A7);
    ccte_host_model_inst.wr(REG_LOAD, 32'h0000_0001);
    step(1'b0, 1'b1, 8'h0C);
    step(1'b0, 1'b0, 8'h00);
    ccte_host_model_inst.rd(REG_STATUS, q, err);
    check("in range", 32'h1, {24'h0, q[7:0]});
    ccte_host_model_inst.wr(REG_NEWVAL, 32'h0000_C350);
    ccte_host_model_inst.wr(REG_MODE, 32'h0000_0006);
    ccte_host_model_inst.wr(REG_CTRL, 32'h0000_0005);
    set_count(32'h0000_C350);
    step(1'b0, 1'b0, 8'h00);
    ccte_host_model_inst.rd(REG_COUNT, q, err);
    check("ring wrap", 32'h0, q);
    ccte_host_model_inst.wr(REG_LOAD, 32'h0000_0002);
    ccte_host_model_inst.rd(REG_STATUS, q, err);
    check("target table", 32'h1, {30'h0, q[STAT_RNG_BIT], q[STAT_CMP_BIT]});
    ccte_host_model_inst.wr(REG_TABLE_BASE, 32'h0000_0002);
    ccte_host_model_inst.wr(REG_TABLE_BASE + 12'h004, 32'h0000_0100);
    ccte_host_model_inst.wr(REG_TABLE_BASE + 12'h008, 32'h0000_0000);
    ccte_host_model_inst.wr(REG_TABLE_BASE + 12'h00C, 32'h0000_0021);
    ccte_host_model_inst.wr(REG_TABLE_BASE + 12'h010, 32'h0000_0100);
    ccte_host_model_inst.wr(REG_TABLE_BASE + 12'h014, 32'h0000_0000);
    ccte_host_model_inst.wr(REG_TABLE_BASE + 12'h018, 32'h0000_0022);
    set_count(32'h0000_00FF);
    // Both entries match on one step; the earlier one is served first.
    up_pulse <= 1'b1;
    serve(8'h21, 8'h01);
    serve(8'h22, 8'h02);
    up_pulse <= 1'b0;
    repeat (1300) @(posedge pclk);
    @(negedge pclk);
    check("resumed", 32'h0, {31'h0, cyclic_suspend});
    ccte_host_model_inst.wr(REG_CTRL, 32'h0000_000E);
    repeat (2) @(posedge pclk);
    ccte_host_model_inst.rd(REG_STATUS, q, err);
    check("cont after reset", 32'h1, {31'h0, q[STAT_CMP_BIT]});
    ccte_host_model_inst.wr(REG_CTRL, 32'h0000_000C);
    repeat (2) @(posedge pclk);
    ccte_host_model_inst.rd(REG_STATUS, q, err);
    check("stop after reset", 32'h0, {31'h0, q[STAT_CMP_BIT]});
    ccte_host_model_inst.rd(REG_COUNT, q, err);
    check("count reset", 32'h0, q);
    ccte_host_model_inst.wr(REG_MODE, 32'h0000_0000);
    ccte_host_model_inst.rd(REG_STATUS, q, err);
    check("started", 32'h1, {31'h0, q[STAT_CMP_BIT]});
    ccte_host_model_inst.wr(REG_MODE, 32'h0000_0001);
    ccte_host_model_inst.rd(REG_STATUS, q, err);
    check("stopped", 32'h0, {31'h0, q[STAT_CMP_BIT]});
    // At the 60 kHz setting a 1600-cycle pulse is taken as noise and dropped.
    ccte_host_model_inst.wr(REG_CTRL, 32'h0000_0000);
    up_pulse <= 1'b1;
    repeat (1600) @(posedge pclk);
    up_pulse <= 1'b0;
    repeat (2200) @(posedge pclk);
    ccte_host_model_inst.rd(REG_COUNT, q, err);
    check("short pulse", 32'h0, q);
    up_pulse <= 1'b1;
    repeat (2200) @(posedge pclk);
    up_pulse <= 1'b0;
    repeat (2200) @(posedge pclk);
    ccte_host_model_inst.rd(REG_COUNT, q, err);
    check("slow pulse", 32'h1, q);
    finish_test();
  end
endmodule
